// ===== rgmc_top.sv
// top: apb register file, filter calibration timer, gain loop and fsk divider select
//
// The placing of the registers and register access over APB were decided locally.
module rgmc_top #(
   parameter int CAL_CYCLES = rgmc_pkg::CAL_CYCLES
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [6:0] received_level_measure, // 7-bit level code from converter
   input wire logic transmit_bit_line, // transmit data bit
   output logic [22:0] synth_divider, // divider value incl. fsk offset
   output rgmc_pkg::rgmc_ctrl_t ctrl // analog control bundle
);
   typedef enum {ST_IDLE, ST_WAIT} rgmc_agc_t;
   logic [31:0] divider_reg, osc_reg, txmod_reg, rxclk_reg, demod_reg, correl_reg;
   logic [6:0] low_thr_reg, high_thr_reg;
   logic [1:0] auto_sel_reg, amp_gain_reg, filt_gain_reg;
   logic [7:0] delay_reg;
   logic [15:0] seq_div_reg;
   logic [22:0] center_reg;
   logic [6:0] level_reg;
   logic [17:0] cal_cnt_reg;
   logic cal_busy_reg;
   logic [23:0] wait_cnt_reg;
   logic [2:0] steps_reg;
   rgmc_agc_t agc_reg;
   logic agc_on, wr_en, rd_en, mapped, step_down, step_up;
   logic [31:0] rd_mux;
   logic [22:0] div_reg;
   logic [8:0] dev;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = a inside {rgmc_pkg::ADDR_DIVIDER, rgmc_pkg::ADDR_OSC_FILTER,
         rgmc_pkg::ADDR_TX_MOD, rgmc_pkg::ADDR_RX_CLOCK, rgmc_pkg::ADDR_DEMOD,
         rgmc_pkg::ADDR_CORREL, rgmc_pkg::ADDR_GAIN_CTRL, rgmc_pkg::ADDR_GAIN_DELAY,
         rgmc_pkg::ADDR_READBACK, rgmc_pkg::ADDR_STATUS, rgmc_pkg::ADDR_CENTER};
   endfunction : is_mapped

   assign mapped = is_mapped(paddr);
   assign wr_en = psel && penable && pwrite && mapped;
   // read data is captured in the setup cycle so it stands through the access phase
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign agc_on = &auto_sel_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider_reg <= rgmc_pkg::RST_DIVIDER;
         osc_reg <= rgmc_pkg::RST_OSC_FILTER;
         txmod_reg <= rgmc_pkg::RST_TX_MOD;
         rxclk_reg <= rgmc_pkg::RST_RX_CLOCK;
         demod_reg <= rgmc_pkg::RST_DEMOD;
         correl_reg <= rgmc_pkg::RST_CORREL;
         low_thr_reg <= rgmc_pkg::RST_LOW_THR;
         high_thr_reg <= rgmc_pkg::RST_HIGH_THR;
         auto_sel_reg <= 2'h0;
         delay_reg <= rgmc_pkg::RST_GAIN_DELAY;
         seq_div_reg <= rgmc_pkg::RST_SEQ_DIV;
         center_reg <= 23'h000000;
      end else if (wr_en && !cal_busy_reg) begin
         unique case (paddr)
            rgmc_pkg::ADDR_DIVIDER: divider_reg <= pwdata;
            rgmc_pkg::ADDR_OSC_FILTER: osc_reg <= pwdata;
            rgmc_pkg::ADDR_TX_MOD: txmod_reg <= pwdata;
            rgmc_pkg::ADDR_RX_CLOCK: rxclk_reg <= pwdata;
            rgmc_pkg::ADDR_DEMOD: demod_reg <= pwdata;
            rgmc_pkg::ADDR_CORREL: correl_reg <= pwdata & ~(32'h1 << rgmc_pkg::CORR_CAL_START);
            rgmc_pkg::ADDR_GAIN_CTRL: begin
               low_thr_reg <= pwdata[rgmc_pkg::GAIN_LOW_LO +: 7];
               high_thr_reg <= pwdata[rgmc_pkg::GAIN_HIGH_LO +: 7];
               auto_sel_reg <= {pwdata[rgmc_pkg::GAIN_AUTO_B], pwdata[rgmc_pkg::GAIN_AUTO_A]};
            end
            rgmc_pkg::ADDR_GAIN_DELAY: begin
               delay_reg <= pwdata[rgmc_pkg::GDLY_DELAY_LO +: 8];
               seq_div_reg <= pwdata[rgmc_pkg::GDLY_SEQDIV_LO +: 16];
            end
            rgmc_pkg::ADDR_CENTER: center_reg <= pwdata[22:0];
            default: ;
         endcase
      end
   end

   // calibration: self-timed, bus writes ignored while it runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_busy_reg <= 1'b0;
         cal_cnt_reg <= 18'h00000;
      end else if (cal_busy_reg) begin
         if (cal_cnt_reg == 18'(CAL_CYCLES - 1)) begin
            cal_busy_reg <= 1'b0;
         end
         cal_cnt_reg <= cal_cnt_reg + 18'h00001;
      end else if (wr_en && paddr == rgmc_pkg::ADDR_CORREL
            && pwdata[rgmc_pkg::CORR_CAL_START]) begin
         cal_busy_reg <= 1'b1;
         cal_cnt_reg <= 18'h00000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 7'h00;
      end else begin
         level_reg <= (received_level_measure > rgmc_pkg::LEVEL_MAX) ?
            rgmc_pkg::LEVEL_MAX : received_level_measure;
      end
   end

   assign step_down = level_reg > high_thr_reg;
   assign step_up = level_reg < low_thr_reg;

   // gain loop; gain order from top: amp11/f10, amp10/f10, amp10/f01, amp10/f00, 01/00, 00/00
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         agc_reg <= ST_IDLE;
         wait_cnt_reg <= 24'h000000;
         steps_reg <= 3'h0;
         amp_gain_reg <= rgmc_pkg::AMP_HIGH;
         filt_gain_reg <= rgmc_pkg::FILT_HIGH;
      end else if (wr_en && !cal_busy_reg && paddr == rgmc_pkg::ADDR_GAIN_CTRL) begin
         amp_gain_reg <= pwdata[rgmc_pkg::GAIN_AMP_LO +: 2];
         filt_gain_reg <= pwdata[rgmc_pkg::GAIN_FILT_LO +: 2];
         agc_reg <= ST_IDLE;
         steps_reg <= 3'h0;
      end else if (!agc_on) begin
         agc_reg <= ST_IDLE;
         steps_reg <= 3'h0;
      end else begin
         unique case (agc_reg)
            ST_IDLE: begin
               if (steps_reg < 3'(rgmc_pkg::GAIN_STEPS_MAX) && (step_down || step_up)) begin
                  agc_reg <= ST_WAIT;
                  steps_reg <= steps_reg + 3'h1;
                  wait_cnt_reg <= 24'(delay_reg * seq_div_reg);
                  if (step_down) begin
                     if (amp_gain_reg == rgmc_pkg::AMP_HIGH) begin
                        amp_gain_reg <= rgmc_pkg::AMP_MED;
                     end else if (amp_gain_reg == rgmc_pkg::AMP_MED
                           && filt_gain_reg != rgmc_pkg::FILT_LOW) begin
                        filt_gain_reg <= filt_gain_reg - 2'h1;
                     end else if (amp_gain_reg != rgmc_pkg::AMP_XLOW) begin
                        amp_gain_reg <= amp_gain_reg - 2'h1;
                     end
                  end else begin
                     if (amp_gain_reg == rgmc_pkg::AMP_XLOW
                           || amp_gain_reg == rgmc_pkg::AMP_LOW) begin
                        amp_gain_reg <= amp_gain_reg + 2'h1;
                     end else if (amp_gain_reg == rgmc_pkg::AMP_MED
                           && filt_gain_reg != rgmc_pkg::FILT_HIGH) begin
                        filt_gain_reg <= filt_gain_reg + 2'h1;
                     end else begin
                        amp_gain_reg <= rgmc_pkg::AMP_HIGH;
                        filt_gain_reg <= rgmc_pkg::FILT_HIGH;
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (wait_cnt_reg <= 24'h000001) begin
                  agc_reg <= ST_IDLE;
               end
               wait_cnt_reg <= wait_cnt_reg - 24'h000001;
            end
            default: agc_reg <= ST_IDLE;
         endcase
      end
   end

   assign dev = txmod_reg[rgmc_pkg::TXMOD_DEV_LO +: 9];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 23'h000000;
      end else begin
         div_reg <= transmit_bit_line ? center_reg + 23'(dev) : center_reg - 23'(dev);
      end
   end
   assign synth_divider = div_reg;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         rgmc_pkg::ADDR_DIVIDER: rd_mux = divider_reg;
         rgmc_pkg::ADDR_OSC_FILTER: rd_mux = osc_reg;
         rgmc_pkg::ADDR_TX_MOD: rd_mux = txmod_reg;
         rgmc_pkg::ADDR_RX_CLOCK: rd_mux = rxclk_reg;
         rgmc_pkg::ADDR_DEMOD: rd_mux = demod_reg;
         rgmc_pkg::ADDR_CORREL: rd_mux = correl_reg;
         rgmc_pkg::ADDR_GAIN_CTRL: rd_mux = {8'h00, filt_gain_reg, amp_gain_reg, auto_sel_reg,
            high_thr_reg, low_thr_reg, 4'h0};
         rgmc_pkg::ADDR_GAIN_DELAY: rd_mux = {8'h00, seq_div_reg, delay_reg};
         rgmc_pkg::ADDR_READBACK: rd_mux = {21'h000000, level_reg, amp_gain_reg,
            filt_gain_reg};
         rgmc_pkg::ADDR_STATUS: rd_mux = cal_busy_reg ? rgmc_pkg::RV_STATUS_CAL : 32'h0000_0000;
         rgmc_pkg::ADDR_CENTER: rd_mux = {9'h000, center_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= rd_mux;
      end
   end

   always_comb begin
      ctrl.pa_enable = txmod_reg[rgmc_pkg::TXMOD_PA_EN];
      ctrl.pa_power = txmod_reg[rgmc_pkg::TXMOD_POWER_LO +: 6];
      ctrl.pa_bias = txmod_reg[rgmc_pkg::TXMOD_BIAS_LO +: 2];
      ctrl.mod_scheme = txmod_reg[rgmc_pkg::TXMOD_SCHEME_LO +: 3];
      ctrl.amp_input_short_switch = !divider_reg[rgmc_pkg::DIV_RXTX];
      ctrl.front_amp_mode_select = correl_reg[rgmc_pkg::CORR_AMP_MODE];
      ctrl.mixer_linearity = correl_reg[rgmc_pkg::CORR_MIXER_LIN];
      ctrl.filter_bw = osc_reg[rgmc_pkg::OSC_BW_LO +: 2];
      ctrl.offset_clock_divider = rxclk_reg[rgmc_pkg::RXCLK_OFS_LO +: 2];
      ctrl.corr_demod_en = demod_reg[rgmc_pkg::DEMOD_SEL_LO +: 2] == rgmc_pkg::DEMOD_CORREL;
      ctrl.linear_demod_en =
         demod_reg[rgmc_pkg::DEMOD_SEL_LO +: 2] == rgmc_pkg::DEMOD_LINEAR;
      ctrl.front_amp_gain_field = amp_gain_reg;
      ctrl.filter_gain = filt_gain_reg;
      ctrl.filter_cal_busy = cal_busy_reg;
   end

   property p_cal_start;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && !cal_busy_reg && paddr == rgmc_pkg::ADDR_CORREL
         && pwdata[rgmc_pkg::CORR_CAL_START])
      |=> cal_busy_reg;
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
   property p_cal_end;
      @(posedge pclk) disable iff (!presetn)
      $fell(cal_busy_reg) |-> $past(cal_cnt_reg) == 18'(CAL_CYCLES - 1);
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration length wrong");
   property p_agc_off;
      @(posedge pclk) disable iff (!presetn)
      !agc_on |-> agc_reg == ST_IDLE;
   endproperty
   a_agc_off: assert property (p_agc_off) else $error("gain loop active while disabled");
   property p_manual_gain;
      @(posedge pclk) disable iff (!presetn)
      (!agc_on && !wr_en) |=> $stable(filt_gain_reg);
   endproperty
   a_manual_gain: assert property (p_manual_gain) else $error("filter gain moved");
   property p_steps;
      @(posedge pclk) disable iff (!presetn)
      steps_reg <= 3'(rgmc_pkg::GAIN_STEPS_MAX);
   endproperty
   a_steps: assert property (p_steps) else $error("too many gain steps");
   property p_wait;
      @(posedge pclk) disable iff (!presetn)
      (agc_reg == ST_IDLE ##1 agc_reg == ST_WAIT) |->
         wait_cnt_reg == 24'($past(delay_reg) * $past(seq_div_reg));
   endproperty
   a_wait: assert property (p_wait) else $error("step wait wrong");
   property p_fsk;
      @(posedge pclk) disable iff (!presetn)
      ##1 synth_divider == ($past(transmit_bit_line) ? $past(center_reg) + 23'($past(dev))
         : $past(center_reg) - 23'($past(dev)));
   endproperty
   a_fsk: assert property (p_fsk) else $error("fsk divider wrong");
   property p_short;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && !cal_busy_reg && paddr == rgmc_pkg::ADDR_DIVIDER)
      |=> ctrl.amp_input_short_switch == !$past(pwdata[rgmc_pkg::DIV_RXTX]);
   endproperty
   a_short: assert property (p_short) else $error("switch state wrong");
   property p_level;
      @(posedge pclk) disable iff (!presetn)
      level_reg <= rgmc_pkg::LEVEL_MAX;
   endproperty
   a_level: assert property (p_level) else $error("level code above range");
   c_cal: cover property (@(posedge pclk) disable iff (!presetn) $fell(cal_busy_reg));
   c_down: cover property (@(posedge pclk) disable iff (!presetn)
      agc_on && step_down && agc_reg == ST_IDLE);
   c_up: cover property (@(posedge pclk) disable iff (!presetn)
      agc_on && step_up && agc_reg == ST_IDLE);
   c_five: cover property (@(posedge pclk) disable iff (!presetn) steps_reg == 3'h5);
endmodule : rgmc_top

// ===== rgmc_pkg.sv
// package: register map, field layout and timing constants for the gain/modulation control block
// Function
// - setting filter calibration start runs a self-timed 200 us calibration
// - both automatic-select bits 18 and 19 set enable the automatic gain loop
// - with gain loop off, host filter gain field sets the filter gain level
// - front amp gain field writable by host and updated by gain loop
// - low threshold bits 4..10 reset 30, high bits 11..17 reset 70
// - step wait is delay times sequencer divider; default delay 10, keep at least 25 us
// - gain loop passes through at most five gain changes
// - signal level digitised to a 7-bit code, 80 levels, used by readback and loop
// - readback holds level code in bits 4..10 plus amp gain code in bits 2..3 and filter gain code in bits 0..1
// - amp gain codes 11/10/01/00, filter gain codes 10/01/00
// - offset clock divider bits 4..5 selects crystal divide by 4, 8 or 16
// - deviation number bits 15..23, values 1 to 511
// - frequency shift keying offsets the divider up or down by deviation per data bit
// - modulation scheme selected by bits 6..8 of transmit modulation register
// - output power from bits 9..14, independent of the data line level
// - bit 4 clear powers down output stage; bits 30..31 set bias
// - rx/tx select bit 27 zero shorts the receive amplifier input
// - correlator register bit 15 selects amp mode, bit 18 mixer linearity
// - bits 22..23 of oscillator/filter register select channel filter bandwidth
// - demodulator select bits 4..5 choose correlator or linear demodulator
// - demodulator select 01 enables correlator, 00 enables linear
package rgmc_pkg;
   localparam logic [7:0] ADDR_DIVIDER = 8'h00;
   localparam logic [7:0] ADDR_OSC_FILTER = 8'h04;
   localparam logic [7:0] ADDR_TX_MOD = 8'h08;
   localparam logic [7:0] ADDR_RX_CLOCK = 8'h0C;
   localparam logic [7:0] ADDR_DEMOD = 8'h10;
   localparam logic [7:0] ADDR_CORREL = 8'h18;
   localparam logic [7:0] ADDR_GAIN_CTRL = 8'h24;
   localparam logic [7:0] ADDR_GAIN_DELAY = 8'h28;
   localparam logic [7:0] ADDR_READBACK = 8'h40;
   localparam logic [7:0] ADDR_STATUS = 8'h44;
   localparam logic [7:0] ADDR_CENTER = 8'h48;
   localparam int TXMOD_PA_EN = 4;
   localparam int TXMOD_SCHEME_LO = 6;
   localparam int TXMOD_POWER_LO = 9;
   localparam int TXMOD_DEV_LO = 15;
   localparam int TXMOD_BIAS_LO = 30;
   localparam int DIV_RXTX = 27;
   localparam int OSC_BW_LO = 22;
   localparam int RXCLK_OFS_LO = 4;
   localparam int DEMOD_SEL_LO = 4;
   localparam int CORR_AMP_MODE = 15;
   localparam int CORR_MIXER_LIN = 18;
   localparam int CORR_CAL_START = 19;
   localparam int CORR_CAL_DIV_LO = 20;
   localparam int GAIN_LOW_LO = 4;
   localparam int GAIN_HIGH_LO = 11;
   localparam int GAIN_AUTO_A = 18;
   localparam int GAIN_AUTO_B = 19;
   localparam int GAIN_AMP_LO = 20;
   localparam int GAIN_FILT_LO = 22;
   localparam int GDLY_DELAY_LO = 0;
   localparam int GDLY_SEQDIV_LO = 8;
   localparam logic [31:0] RST_DIVIDER = 32'h0800_0000;
   localparam logic [31:0] RST_OSC_FILTER = 32'h0000_0000;
   localparam logic [31:0] RST_TX_MOD = 32'h0000_0010;
   localparam logic [31:0] RST_RX_CLOCK = 32'h0000_0000;
   localparam logic [31:0] RST_DEMOD = 32'h0000_0010;
   localparam logic [31:0] RST_CORREL = 32'h0000_0000;
   localparam logic [6:0] RST_LOW_THR = 7'h1E;
   localparam logic [6:0] RST_HIGH_THR = 7'h46;
   localparam logic [7:0] RST_GAIN_DELAY = 8'h0A;
   localparam logic [15:0] RST_SEQ_DIV = 16'h0001;
   localparam logic [1:0] AMP_HIGH = 2'h3;
   localparam logic [1:0] AMP_MED = 2'h2;
   localparam logic [1:0] AMP_LOW = 2'h1;
   localparam logic [1:0] AMP_XLOW = 2'h0;
   localparam logic [1:0] FILT_HIGH = 2'h2;
   localparam logic [1:0] FILT_MED = 2'h1;
   localparam logic [1:0] FILT_LOW = 2'h0;
   localparam logic [1:0] DEMOD_LINEAR = 2'h0;
   localparam logic [1:0] DEMOD_CORREL = 2'h1;
   localparam logic [6:0] LEVEL_MAX = 7'h4F;
   localparam int GAIN_STEPS_MAX = 5;
   localparam int CLK_MHZ = 250;
   localparam int CAL_TIME_US = 200;
   localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
   localparam logic [31:0] RV_STATUS_CAL = 32'h0000_0001;
   typedef struct packed {
      logic pa_enable;
      logic [5:0] pa_power;
      logic [1:0] pa_bias;
      logic [2:0] mod_scheme;
      logic amp_input_short_switch;
      logic front_amp_mode_select;
      logic mixer_linearity;
      logic [1:0] filter_bw;
      logic [1:0] offset_clock_divider;
      logic corr_demod_en;
      logic linear_demod_en;
      logic [1:0] front_amp_gain_field;
      logic [1:0] filter_gain;
      logic filter_cal_busy;
   } rgmc_ctrl_t;
endpackage : rgmc_pkg

// ===== rgmc_host_model.sv
// host side apb master model that programs the control block
module rgmc_host_model (
   input wire logic pclk, // clock
   input wire logic pready, // slave ready
   input wire logic [31:0] prdata, // read data
   input wire logic pslverr, // slave error
   output logic psel, // select
   output logic penable, // enable
   output logic pwrite, // direction
   output logic [7:0] paddr, // byte address
   output logic [31:0] pwdata // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // one transfer; starts a clock after the previous release so no signal moves twice at one edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : rgmc_host_model

// ===== test_radio_gain_and_modulation_control.sv
// self-checking testbench for the gain and modulation control block
module test_radio_gain_and_modulation_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CAL_SIM = 20;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [7:0] e;} rgmc_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] level = 7'h40;
   logic tx_bit = 1'b0;
   logic [22:0] synth_divider;
   rgmc_pkg::rgmc_ctrl_t ctrl;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   rgmc_row_t rows [15];
   always #2 pclk = ~pclk;
   rgmc_top #(.CAL_CYCLES(CAL_SIM)) rgmc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .received_level_measure(level),
      .transmit_bit_line(tx_bit), .synth_divider(synth_divider), .ctrl(ctrl));
   rgmc_host_model rgmc_host_model_inst (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      rgmc_host_model_inst.xfer(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      rgmc_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rd, err);
   endtask : rdr
   task automatic gains(input logic [1:0] amp, input logic [1:0] filt);
      check({30'h0, ctrl.front_amp_gain_field}, {30'h0, amp});
      check({30'h0, ctrl.filter_gain}, {30'h0, filt});
   endtask : gains
   function automatic logic [7:0] fld(input logic [3:0] s);
      case (s)
         4'h0: fld = {7'h0, ctrl.pa_enable};
         4'h1: fld = {2'h0, ctrl.pa_power};
         4'h2: fld = {6'h0, ctrl.pa_bias};
         4'h3: fld = {5'h0, ctrl.mod_scheme};
         4'h4: fld = {7'h0, ctrl.amp_input_short_switch};
         4'h5: fld = {7'h0, ctrl.front_amp_mode_select};
         4'h6: fld = {7'h0, ctrl.mixer_linearity};
         4'h7: fld = {6'h0, ctrl.filter_bw};
         4'h8: fld = {6'h0, ctrl.offset_clock_divider};
         4'h9: fld = {7'h0, ctrl.corr_demod_en};
         4'hA: fld = {7'h0, ctrl.linear_demod_en};
         4'hB: fld = {6'h0, ctrl.front_amp_gain_field};
         default: fld = {6'h0, ctrl.filter_gain};
      endcase
   endfunction : fld
   task automatic final_report();
      $display("tests done: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      rows = '{'{8'h08, 32'h8002_D550, 4'h1, 8'h2A}, '{8'h08, 32'h8002_D550, 4'h3, 8'h05},
         '{8'h08, 32'h8002_D550, 4'h2, 8'h02}, '{8'h08, 32'h0002_D540, 4'h0, 8'h00},
         '{8'h00, 32'h0000_0000, 4'h4, 8'h01}, '{8'h00, 32'h0800_0000, 4'h4, 8'h00},
         '{8'h18, 32'h0000_8000, 4'h5, 8'h01}, '{8'h18, 32'h0004_0000, 4'h6, 8'h01},
         '{8'h04, 32'h0040_0000, 4'h7, 8'h01}, '{8'h04, 32'h0080_0000, 4'h7, 8'h02},
         '{8'h0C, 32'h0000_0020, 4'h8, 8'h02}, '{8'h10, 32'h0000_0000, 4'hA, 8'h01},
         '{8'h10, 32'h0000_0010, 4'h9, 8'h01}, '{8'h24, 32'h0052_31E0, 4'hB, 8'h01},
         '{8'h24, 32'h0052_31E0, 4'hC, 8'h01}};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdr(rgmc_pkg::ADDR_GAIN_CTRL);
      check({25'h0, rd[10:4]}, 32'd30);
      check({25'h0, rd[17:11]}, 32'd70);
      check({8'h0, fld(4'h0), fld(4'h4), fld(4'h9)}, 32'h0001_0001);
      gains(2'h3, 2'h2);
      rdr(rgmc_pkg::ADDR_GAIN_DELAY);
      check({24'h0, rd[7:0]}, 32'd10);
      $display("test reset done");
      for (int i = 0; i < 15; i++) begin
         wr(rows[i].a, rows[i].d);
         rdr(rows[i].a);
         check(rd, rows[i].d);
         check({24'h0, fld(rows[i].s)}, {24'h0, rows[i].e});
      end
      $display("test table done");
      rdr(8'h30);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      $display("test unmapped done");
      wr(rgmc_pkg::ADDR_CENTER, 32'h0001_0000);
      wr(rgmc_pkg::ADDR_TX_MOD, 32'h00FF_D550);
      @(posedge pclk) tx_bit <= 1'b1;
      repeat (3) @(posedge pclk);
      check({9'h0, synth_divider}, 32'h0001_01FF);
      @(posedge pclk) tx_bit <= 1'b0;
      repeat (3) @(posedge pclk);
      check({9'h0, synth_divider}, 32'h0000_FE01);
      check({24'h0, fld(4'h1)}, 32'h2A);
      $display("test fsk done");
      wr(rgmc_pkg::ADDR_GAIN_DELAY, 32'h0000_0102);
      @(posedge pclk) level <= 7'h7F;
      wr(rgmc_pkg::ADDR_GAIN_CTRL, 32'h00BE_78F0);
      repeat (30) @(posedge pclk);
      gains(2'h3, 2'h2);
      wr(rgmc_pkg::ADDR_GAIN_CTRL, 32'h00BE_31E0);
      repeat (60) @(posedge pclk);
      gains(2'h0, 2'h0);
      rdr(rgmc_pkg::ADDR_READBACK);
      check({28'h0, rd[3:0]}, 32'h0);
      check({25'h0, rd[10:4]}, {25'h0, rgmc_pkg::LEVEL_MAX});
      @(posedge pclk) level <= 7'h00;
      repeat (60) @(posedge pclk);
      gains(2'h0, 2'h0);
      wr(rgmc_pkg::ADDR_GAIN_CTRL, 32'h0014_31E0);
      repeat (30) @(posedge pclk);
      gains(2'h1, 2'h0);
      wr(rgmc_pkg::ADDR_GAIN_DELAY, 32'h0000_0114);
      wr(rgmc_pkg::ADDR_GAIN_CTRL, 32'h000E_31E0);
      repeat (8) @(posedge pclk);
      gains(2'h1, 2'h0);
      repeat (22) @(posedge pclk);
      gains(2'h2, 2'h0);
      $display("test gain loop done");
      wr(rgmc_pkg::ADDR_CORREL, 32'h00A0_0000);
      wr(rgmc_pkg::ADDR_CORREL, 32'h00A8_0000);
      n = 0;
      // bus left idle while the calibration runs
      repeat (60) begin
         @(posedge pclk);
         if (ctrl.filter_cal_busy === 1'b1) n++;
      end
      check(n, CAL_SIM);
      rdr(rgmc_pkg::ADDR_CORREL);
      check(rd, 32'h00A0_0000);
      rdr(rgmc_pkg::ADDR_STATUS);
      check({31'h0, rd[0]}, 32'h0);
      $display("test calibration done");
      final_report();
   end
endmodule : test_radio_gain_and_modulation_control
